// >>> hdl/capture_defs.svh
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_RUN_CTRL 6'h00
`define OFS_MODE 6'h04
`define OFS_CONFIG 6'h08
`define OFS_LINE_CNT0 6'h0C
`define OFS_LINE_CNT1 6'h10
`define OFS_LINE_CNT2 6'h14
`define OFS_HSYNC_WIDTH 6'h18
`define OFS_VSYNC_WIDTH 6'h1C
`define OFS_PIXELS_LINE 6'h20
`define OFS_LINES_FRAME 6'h24
`define OFS_MEM_ADDR 6'h28
`define OFS_STATUS 6'h2C
`define OFS_DEFECT_CTL 6'h30

// ==========================================================
// Field positions
`define RUN_BIT 0
`define MEMWR_BIT 1
`define SYNCDIR_BIT 0
`define VSPOL_BIT 1
`define BT656_BIT 2
`define PARITY_BIT 3
`define BYPASS_BIT 0
`define BUSY_BIT 0
`define WAIT_BIT 1

// ==========================================================
// Reset values
`define RST_LINE_CNT 16'h0000
`define RST_HSYNC_WIDTH 16'h0001
`define RST_VSYNC_WIDTH 16'h0001
`define RST_PIXELS_LINE 16'h0010
`define RST_LINES_FRAME 16'h0010
`define RST_MEM_ADDR 32'h0000_0000
`define RST_DEFECT_CTL 32'h0000_0000

`endif

// >>> hdl/capture_pkg.sv
package capture_pkg;

    // ==========================================================
    // Sync generator timing, shadowed as one group
    typedef struct packed {
        logic [15:0] hsyncWidth;
        logic [15:0] vsyncWidth;
        logic [15:0] pixelsPerLine;
        logic [15:0] linesPerFrame;
    } syncTiming_t;

    // Everything that latches at frame start
    typedef struct packed {
        logic memWrite;
        logic [31:0] memAddr;
        syncTiming_t timing;
    } shadowSet_t;

    // AHB address phase held for the data phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [5:0] offset;
    } ahbPhase_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_ACTIVE = 2'b10
    } frameState_t;

endpackage

// >>> hdl/image_sensor_interface.sv
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "capture_defs.svh"
module image_sensor_interface
    import capture_pkg::*;
#(
    parameter int DATA_WIDTH = 12
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Sensor pins
    input wire logic pixelClock,
    input wire logic [DATA_WIDTH-1:0] pixelData,
    input wire logic fieldIdIn,
    input wire logic hsyncIn,
    output logic hsyncOut,
    output logic hsyncOe_n,
    input wire logic vsyncIn,
    output logic vsyncOut,
    output logic vsyncOe_n,
    // Datapath side
    input wire logic lensShadeEvent,
    output logic [DATA_WIDTH-1:0] capturedPixel,
    output logic capturedValid,
    output logic [31:0] memAddr,
    output logic [31:0] defectMemCtl,
    // Interrupt pulses
    output logic [2:0] lineCountIrq,
    output logic lensShadingIrq
);

    // Pixel width must fit the 32-bit register views
    if (DATA_WIDTH < 1 || DATA_WIDTH > 32) begin : g_badWidth
        $error("DATA_WIDTH out of range");
    end

    // ==========================================================
    // Pin synchronisers: first stage feeds only the second
    logic [DATA_WIDTH+3:0] pinMeta_q, pinSync_q;
    logic pclkPrev_q, hsPrev_q, vsPrev_q;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            pinMeta_q <= {pixelData, fieldIdIn, hsyncIn, vsyncIn, pixelClock};
            pinSync_q <= pinMeta_q;
        end
    end
    logic pixEdge;
    assign pixEdge = pinSync_q[0] & ~pclkPrev_q;

    // ==========================================================
    // Registers
    ahbPhase_t phase_q, phase_d;
    logic run_q, run_d, memWrPend_q, memWrPend_d;
    logic [2:0] mode_q, mode_d;
    logic bypass_q, bypass_d;
    logic [15:0] lineCount_q [3], lineCount_d [3];
    logic [31:0] memAddrPend_q, memAddrPend_d, defect_q, defect_d, rdata_q, rdata_d;
    syncTiming_t timingPend_q, timingPend_d;
    shadowSet_t active_q, active_d;
    frameState_t state_q, state_d;
    logic evenField_q, evenField_d;
    logic latchNow, frameStart, hsRise;
    logic master;
    assign master = mode_q[`SYNCDIR_BIT];
    logic [31:0] regView;

    // Read mux, also used to load hrdata
    always_comb begin
        regView = 32'h0000_0000;
        case (haddr[5:0])
            `OFS_RUN_CTRL: regView = {30'h0, memWrPend_q, run_q};
            `OFS_MODE: regView = {28'h0, evenField_q, mode_q};
            `OFS_CONFIG: regView = {31'h0, bypass_q};
            `OFS_LINE_CNT0: regView = {16'h0, lineCount_q[0]};
            `OFS_LINE_CNT1: regView = {16'h0, lineCount_q[1]};
            `OFS_LINE_CNT2: regView = {16'h0, lineCount_q[2]};
            // Shadowed reads return the pending value
            `OFS_HSYNC_WIDTH: regView = {16'h0, timingPend_q.hsyncWidth};
            `OFS_VSYNC_WIDTH: regView = {16'h0, timingPend_q.vsyncWidth};
            `OFS_PIXELS_LINE: regView = {16'h0, timingPend_q.pixelsPerLine};
            `OFS_LINES_FRAME: regView = {16'h0, timingPend_q.linesPerFrame};
            `OFS_MEM_ADDR: regView = memAddrPend_q;
            `OFS_STATUS: regView = {30'h0, state_q == ST_WAIT, state_q == ST_ACTIVE};
            `OFS_DEFECT_CTL: regView = defect_q;
            default: regView = 32'h0000_0000;
        endcase
    end

    // Bus and register next values; writes land in the data phase
    always_comb begin
        phase_d = phase_q;
        run_d = run_q;
        memWrPend_d = memWrPend_q;
        mode_d = mode_q;
        bypass_d = bypass_q;
        lineCount_d = lineCount_q;
        memAddrPend_d = memAddrPend_q;
        defect_d = defect_q;
        timingPend_d = timingPend_q;
        rdata_d = rdata_q;
        if (hready) begin
            phase_d.valid = hsel & htrans[1];
            phase_d.write = hwrite;
            phase_d.offset = haddr[5:0];
            if (hsel & htrans[1] & ~hwrite) begin
                rdata_d = regView;
            end
        end
        if (phase_q.valid & phase_q.write) begin
            case (phase_q.offset)
                `OFS_RUN_CTRL: begin
                    run_d = hwdata[`RUN_BIT];
                    memWrPend_d = hwdata[`MEMWR_BIT];
                end
                `OFS_MODE: mode_d = hwdata[2:0];
                `OFS_CONFIG: bypass_d = hwdata[`BYPASS_BIT];
                `OFS_LINE_CNT0: lineCount_d[0] = hwdata[15:0];
                `OFS_LINE_CNT1: lineCount_d[1] = hwdata[15:0];
                `OFS_LINE_CNT2: lineCount_d[2] = hwdata[15:0];
                `OFS_HSYNC_WIDTH: timingPend_d.hsyncWidth = hwdata[15:0];
                `OFS_VSYNC_WIDTH: timingPend_d.vsyncWidth = hwdata[15:0];
                `OFS_PIXELS_LINE: timingPend_d.pixelsPerLine = hwdata[15:0];
                `OFS_LINES_FRAME: timingPend_d.linesPerFrame = hwdata[15:0];
                `OFS_MEM_ADDR: memAddrPend_d = hwdata;
                `OFS_DEFECT_CTL: defect_d = hwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase_q <= '0;
            run_q <= 1'b0;
            memWrPend_q <= 1'b0;
            mode_q <= 3'h0;
            bypass_q <= 1'b0;
            lineCount_q <= '{default: `RST_LINE_CNT};
            memAddrPend_q <= `RST_MEM_ADDR;
            defect_q <= `RST_DEFECT_CTL;
            timingPend_q <= {`RST_HSYNC_WIDTH, `RST_VSYNC_WIDTH, `RST_PIXELS_LINE,
                             `RST_LINES_FRAME};
            rdata_q <= 32'h0000_0000;
        end else begin
            phase_q <= phase_d;
            run_q <= run_d;
            memWrPend_q <= memWrPend_d;
            mode_q <= mode_d;
            bypass_q <= bypass_d;
            lineCount_q <= lineCount_d;
            memAddrPend_q <= memAddrPend_d;
            defect_q <= defect_d;
            timingPend_q <= timingPend_d;
            rdata_q <= rdata_d;
        end
    end
    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign defectMemCtl = defect_q;

    // ==========================================================
    // Sync generator for master mode, on pixel clock edges
    logic [15:0] genPix_q, genPix_d, genLine_q, genLine_d;
    logic genHs_q, genHs_d, genVs_q, genVs_d;
    always_comb begin
        genPix_d = genPix_q;
        genLine_d = genLine_q;
        genHs_d = genHs_q;
        genVs_d = genVs_q;
        if (~run_q | ~master) begin
            genPix_d = 16'h0000;
            genLine_d = 16'h0000;
            genHs_d = 1'b0;
            genVs_d = 1'b0;
        end else if (pixEdge) begin
            genHs_d = genPix_q < active_q.timing.hsyncWidth;
            genVs_d = genLine_q < active_q.timing.vsyncWidth;
            if (genPix_q + 16'h0001 >= active_q.timing.pixelsPerLine) begin
                genPix_d = 16'h0000;
                genLine_d = (genLine_q + 16'h0001 >= active_q.timing.linesPerFrame) ?
                            16'h0000 : genLine_q + 16'h0001;
            end else begin
                genPix_d = genPix_q + 16'h0001;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            genPix_q <= 16'h0000;
            genLine_q <= 16'h0000;
            genHs_q <= 1'b0;
            genVs_q <= 1'b0;
        end else begin
            genPix_q <= genPix_d;
            genLine_q <= genLine_d;
            genHs_q <= genHs_d;
            genVs_q <= genVs_d;
        end
    end
    assign hsyncOut = genHs_q;
    assign vsyncOut = genVs_q;
    assign hsyncOe_n = ~(master & run_q);
    assign vsyncOe_n = ~(master & run_q);

    // ==========================================================
    // Frame tracking; sync edges sampled only on pixel clock edges
    logic hsEff, vsEff;
    always_comb begin
        hsEff = master ? genHs_q : pinSync_q[2];
        // In slave mode, polarity one counts from the vertical drive, the inverted pin; master mode uses the generated vsync
        vsEff = master ? genVs_q : (pinSync_q[1] ^ mode_q[`VSPOL_BIT]);
    end
    assign frameStart = pixEdge & vsEff & ~vsPrev_q & (state_q != ST_IDLE);
    assign hsRise = pixEdge & hsEff & ~hsPrev_q & (state_q == ST_ACTIVE);
    assign latchNow = bypass_q | frameStart | (state_q == ST_IDLE & run_q);

    always_comb begin
        state_d = state_q;
        active_d = active_q;
        evenField_d = evenField_q;
        if (latchNow) begin
            active_d = {memWrPend_q, memAddrPend_q, timingPend_q};
        end
        case (state_q)
            ST_IDLE: if (run_q) state_d = master ? ST_ACTIVE : ST_WAIT;
            ST_WAIT: if (frameStart) state_d = ST_ACTIVE;
            ST_ACTIVE: state_d = ST_ACTIVE;
            default: state_d = ST_IDLE;
        endcase
        if (~run_q) begin
            state_d = ST_IDLE;
        end
        if (frameStart) begin
            // BT.656 reports the field pin; others alternate each frame
            evenField_d = mode_q[`BT656_BIT] ? ~pinSync_q[3] : ~evenField_q;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            active_q <= {1'b0, `RST_MEM_ADDR, `RST_HSYNC_WIDTH, `RST_VSYNC_WIDTH,
                         `RST_PIXELS_LINE, `RST_LINES_FRAME};
            evenField_q <= 1'b0;
            pclkPrev_q <= 1'b0;
            hsPrev_q <= 1'b0;
            vsPrev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            active_q <= active_d;
            evenField_q <= evenField_d;
            pclkPrev_q <= pinSync_q[0];
            if (pixEdge) begin
                hsPrev_q <= hsEff;
                vsPrev_q <= vsEff;
            end
        end
    end
    assign memAddr = active_q.memAddr;

    // ==========================================================
    // Pixel capture into the datapath
    logic [DATA_WIDTH-1:0] pix_q, pix_d;
    logic pixValid_q, pixValid_d;
    always_comb begin
        pix_d = pix_q;
        pixValid_d = pixEdge & (state_q == ST_ACTIVE) & run_q & active_q.memWrite;
        if (pixValid_d) begin
            pix_d = pinSync_q[DATA_WIDTH+3:4];
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pix_q <= '0;
            pixValid_q <= 1'b0;
        end else begin
            pix_q <= pix_d;
            pixValid_q <= pixValid_d;
        end
    end
    assign capturedPixel = pix_q;
    assign capturedValid = pixValid_q;

    // ==========================================================
    // Line-count interrupts, one counter each; a vsync per field
    // in BT.656 restarts them, so each fires once per field
    logic [15:0] hsCnt_q [3];
    logic [2:0] armed_q, irq_q;
    for (genvar i = 0; i < 3; i++) begin : g_lineIrq
        logic [15:0] cnt_d;
        logic armed_d, irq_d;
        always_comb begin
            cnt_d = hsCnt_q[i];
            armed_d = armed_q[i];
            irq_d = 1'b0;
            if (frameStart) begin
                cnt_d = 16'h0000;
                armed_d = 1'b1;
            end else if (hsRise) begin
                cnt_d = hsCnt_q[i] + 16'h0001;
                if (armed_q[i] && cnt_d == lineCount_q[i]) begin
                    irq_d = run_q;
                    armed_d = 1'b0;
                end
            end
            if (~run_q) begin
                armed_d = 1'b0;
            end
        end
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                hsCnt_q[i] <= 16'h0000;
                armed_q[i] <= 1'b0;
                irq_q[i] <= 1'b0;
            end else begin
                hsCnt_q[i] <= cnt_d;
                armed_q[i] <= armed_d;
                irq_q[i] <= irq_d;
            end
        end
    end
    assign lineCountIrq = irq_q;

    // Lens-shading event is already on this clock
    logic lscIrq_q;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lscIrq_q <= 1'b0;
        end else begin
            lscIrq_q <= lensShadeEvent & run_q;
        end
    end
    assign lensShadingIrq = lscIrq_q;

    // ==========================================================
    // Checks
    a_irq_needs_run: assert property (@(posedge clock) disable iff (sys_rst)
        |lineCountIrq |-> $past(run_q)) else $error("line irq without run");
    a_irq_one_cycle: assert property (@(posedge clock) disable iff (sys_rst)
        lineCountIrq[0] |=> !lineCountIrq[0]) else $error("line irq longer than one cycle");
    a_stop_at_once: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(run_q) |=> state_q == ST_IDLE && !capturedValid) else $error("frame not abandoned");
    a_master_start: assert property (@(posedge clock) disable iff (sys_rst)
        state_q == ST_IDLE && run_q && master |=> state_q == ST_ACTIVE)
        else $error("master did not start");
    a_shadow_hold: assert property (@(posedge clock) disable iff (sys_rst)
        !latchNow |=> active_q.timing == $past(active_q.timing)) else $error("shadow moved");
    a_bypass_apply: assert property (@(posedge clock) disable iff (sys_rst)
        bypass_q ##1 bypass_q |-> active_q.memAddr == $past(memAddrPend_q))
        else $error("bypass did not apply");
    a_pins_driven: assert property (@(posedge clock) disable iff (sys_rst)
        (hsyncOe_n == !(master && run_q) && vsyncOe_n == hsyncOe_n) and (!run_q |=> !hsyncOut))
        else $error("sync drive wrong");
    a_line_match: assert property (@(posedge clock) disable iff (sys_rst)
        irq_q[1] |-> hsCnt_q[1] == lineCount_q[1]) else $error("irq at wrong line");
    a_slave_wait: assert property (@(posedge clock) disable iff (sys_rst)
        state_q == ST_WAIT && !frameStart && run_q |=> state_q == ST_WAIT)
        else $error("slave left wait early");

endmodule

// >>> tb/sensor_model.sv
`timescale 1ns/1ns
module sensor_model #(
    parameter int DW = 12
) (
    // Pins toward the capture block
    output logic pixelClock,
    output logic [DW-1:0] pixelData,
    output logic hsyncDrv,
    output logic vsyncDrv,
    output logic fieldId
);
    // ==========================================================
    // Source state; the clock stands still between frames
    int lineIdx = 0;
    logic vsPol = 1'b0;

    initial begin
        pixelClock = 1'b0;
        pixelData = '0;
        hsyncDrv = 1'b0;
        vsyncDrv = 1'b0;
        fieldId = 1'b0;
    end

    // Pixel clock of 160 ns; data changes every period so stale values show
    task automatic pclk(input int n);
        repeat (n) begin
            #80 pixelClock = 1'b1;
            #80 pixelClock = 1'b0;
            pixelData = pixelData + 1'b1;
        end
    endtask

    // Idle level follows the polarity so only the active edge starts a frame
    task automatic setPol(input logic p);
        vsPol = p;
        vsyncDrv = p;
    endtask

    // Field pin level for interlaced input; low marks the even field
    task automatic setField(input logic f);
        fieldId = f;
    endtask

    // Frame start; caller enables the block first so nothing is missed
    task automatic startFrame();
        lineIdx = 0;
        vsyncDrv = ~vsPol;
        pclk(1);
        vsyncDrv = vsPol;
        pclk(2);
    endtask

    // Lines of one hsync pulse and three quiet pixels; no write-enable pin used
    task automatic lines(input int n);
        repeat (n) begin
            hsyncDrv = 1'b1;
            lineIdx++;
            pclk(1);
            hsyncDrv = 1'b0;
            pclk(3);
        end
    endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
`include "capture_defs.svh"
module testbench;
    // ==========================================================
    // Signals
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic hsel = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic lensShadeEvent = 1'b0;
    logic hreadyout, hresp, hsyncOut, hsyncOe_n, vsyncOut, vsyncOe_n;
    logic capturedValid, lensShadingIrq, vsPrev;
    logic [11:0] capturedPixel, pixelData;
    logic [31:0] hrdata, memAddr, defectMemCtl, rd;
    logic [2:0] lineCountIrq;
    logic pixelClock, hsDrv, vsDrv, fieldIdIn;
    wire hsyncIn = hsyncOe_n ? hsDrv : hsyncOut;
    wire vsyncIn = vsyncOe_n ? vsDrv : vsyncOut;
    int errors = 0, tests_run = 0, lensCnt = 0, capCnt = 0, hiLen = 0, hiLast = 0, vsRise = 0;
    int irqCnt [3];
    int irqLine [3];

    always #5 clock = ~clock;

    sensor_model #(.DW(12)) sensor (.pixelClock(pixelClock), .pixelData(pixelData),
        .hsyncDrv(hsDrv), .vsyncDrv(vsDrv), .fieldId(fieldIdIn));

    image_sensor_interface #(.DATA_WIDTH(12)) uut (.clock(clock), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pixelClock(pixelClock), .pixelData(pixelData),
        .fieldIdIn(fieldIdIn), .hsyncIn(hsyncIn), .hsyncOut(hsyncOut),
        .hsyncOe_n(hsyncOe_n), .vsyncIn(vsyncIn), .vsyncOut(vsyncOut),
        .vsyncOe_n(vsyncOe_n), .lensShadeEvent(lensShadeEvent),
        .capturedPixel(capturedPixel), .capturedValid(capturedValid), .memAddr(memAddr),
        .defectMemCtl(defectMemCtl), .lineCountIrq(lineCountIrq),
        .lensShadingIrq(lensShadingIrq));

    // Counts cycles high, so a pulse longer than one cycle counts once per cycle high
    always @(posedge clock) begin
        for (int i = 0; i < 3; i++) begin
            if (lineCountIrq[i] === 1'b1) begin
                irqCnt[i]++;
                irqLine[i] = sensor.lineIdx;
            end
        end
        if (lensShadingIrq === 1'b1) lensCnt++;
        if (capturedValid === 1'b1) capCnt++;
        hiLen = (hsyncOut === 1'b1) ? hiLen + 1 : 0;
        if (hsyncOut === 1'b1) hiLast = hiLen;
        if (vsyncOut === 1'b1 && vsPrev !== 1'b1) vsRise++;
        vsPrev = vsyncOut;
    end

    // ==========================================================
    // Shared tasks
    task automatic summarize();
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task automatic waitRdy();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            errors++;
            summarize();
        end
    endtask

    task automatic busWr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        hsize <= 3'h2;
        htrans <= 2'h2;
        haddr <= {26'h0, a};
        hwrite <= 1'b1;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
    endtask

    task automatic busRd(input logic [5:0] a);
        @(posedge clock);
        hsel <= 1'b1;
        hsize <= 3'h2;
        htrans <= 2'h2;
        haddr <= {26'h0, a};
        hwrite <= 1'b0;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        waitRdy();
        rd = hrdata;
    endtask

    task automatic rdChk(input logic [5:0] a, input logic [31:0] e, input string m);
        busRd(a);
        check(rd, e, m);
    endtask

    task automatic clr();
        irqCnt = '{0, 0, 0};
        irqLine = '{0, 0, 0};
        lensCnt = 0;
        capCnt = 0;
    endtask

    // Each line counter fires n times, at its own programmed line
    task automatic irqChk(input int n);
        for (int i = 0; i < 3; i++) begin
            check(irqCnt[i], n, "line irq count");
            if (n > 0) check(irqLine[i], i + 1, "line irq position");
        end
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        rdChk(`OFS_RUN_CTRL, 32'h0, "run reset");
        rdChk(`OFS_LINE_CNT0, {16'h0, `RST_LINE_CNT}, "count reset");
        rdChk(`OFS_HSYNC_WIDTH, {16'h0, `RST_HSYNC_WIDTH}, "hwidth reset");
        rdChk(`OFS_VSYNC_WIDTH, {16'h0, `RST_VSYNC_WIDTH}, "vwidth reset");
        rdChk(`OFS_PIXELS_LINE, {16'h0, `RST_PIXELS_LINE}, "pixels reset");
        rdChk(`OFS_LINES_FRAME, {16'h0, `RST_LINES_FRAME}, "lines reset");
        rdChk(`OFS_MEM_ADDR, `RST_MEM_ADDR, "pointer reset");
        rdChk(6'h3C, 32'h0, "unmapped read");
        rdChk(`OFS_DEFECT_CTL, `RST_DEFECT_CTL, "defect reset");
        check(hresp, 32'h0, "okay response");
        // Interrupts stay quiet while the run bit is clear
        busWr(`OFS_LINE_CNT0, 32'h1);
        busWr(`OFS_LINE_CNT1, 32'h2);
        busWr(`OFS_LINE_CNT2, 32'h3);
        clr();
        sensor.startFrame();
        sensor.lines(4);
        @(posedge clock) lensShadeEvent <= 1'b1;
        @(posedge clock) lensShadeEvent <= 1'b0;
        repeat (4) @(posedge clock);
        irqChk(0);
        check(lensCnt, 0, "lens irq gated");
        // Slave mode, two frames back to back
        busWr(`OFS_RUN_CTRL, 32'h1);
        clr();
        repeat (2) begin
            sensor.startFrame();
            sensor.lines(4);
        end
        @(posedge clock) lensShadeEvent <= 1'b1;
        @(posedge clock) lensShadeEvent <= 1'b0;
        repeat (4) @(posedge clock);
        irqChk(2);
        check(lensCnt, 1, "lens irq single");
        // Vertical drive is the inverted pin
        busWr(`OFS_MODE, 32'h2);
        sensor.setPol(1'b1);
        clr();
        sensor.startFrame();
        sensor.lines(4);
        irqChk(1);
        sensor.setPol(1'b0);
        // Interlaced input, even then odd field
        busWr(`OFS_MODE, 32'h4);
        clr();
        sensor.setField(1'b0);
        sensor.startFrame();
        sensor.lines(4);
        rdChk(`OFS_MODE, 32'hC, "even field parity");
        sensor.setField(1'b1);
        sensor.startFrame();
        sensor.lines(4);
        rdChk(`OFS_MODE, 32'h4, "odd field parity");
        irqChk(2);
        busWr(`OFS_MODE, 32'h0);
        // Shadowed pointer and write enable; aligned pointer values only
        busWr(`OFS_MEM_ADDR, 32'h100);
        rdChk(`OFS_MEM_ADDR, 32'h100, "pending readback");
        check(memAddr, 32'h0, "pointer held");
        busWr(`OFS_RUN_CTRL, 32'h3);
        clr();
        sensor.lines(1);
        check(capCnt, 0, "write enable held");
        sensor.startFrame();
        sensor.lines(1);
        check(memAddr, 32'h100, "pointer latched");
        check(capCnt > 0, 1, "write enable latched");
        // Last pixel was sampled before the model's falling-edge increment
        check(capturedPixel, sensor.pixelData - 12'h1, "pixel captured");
        busWr(`OFS_CONFIG, 32'h1);
        busWr(`OFS_MEM_ADDR, 32'h200);
        repeat (3) @(posedge clock);
        check(memAddr, 32'h200, "bypass applies");
        busWr(`OFS_CONFIG, 32'h0);
        // Clearing run mid-frame abandons the rest of it
        busWr(`OFS_RUN_CTRL, 32'h1);
        clr();
        sensor.startFrame();
        sensor.lines(1);
        busWr(`OFS_DEFECT_CTL, 32'h0000_00A5);
        @(posedge clock);
        check(defectMemCtl, 32'h0000_00A5, "defect immediate");
        rdChk(`OFS_DEFECT_CTL, 32'h0000_00A5, "defect readback");
        busWr(`OFS_RUN_CTRL, 32'h0);
        sensor.lines(4);
        check(irqCnt[0] * 100 + irqCnt[1] * 10 + irqCnt[2], 100, "abandon frame");
        // Master mode: generated syncs from programmed timing
        // Pixel clock keeps running while the hsync width is written
        fork
            sensor.pclk(6);
            busWr(`OFS_HSYNC_WIDTH, 32'h2);
        join
        busWr(`OFS_PIXELS_LINE, 32'h8);
        busWr(`OFS_LINES_FRAME, 32'h4);
        busWr(`OFS_MODE, 32'h1);
        busWr(`OFS_RUN_CTRL, 32'h1);
        vsRise = 0;
        sensor.pclk(40);
        check(vsRise > 0, 1, "master starts");
        check(hiLast, 32, "hsync width");
        check(hsyncOe_n, 1'b0, "hsync driven");
        check(vsyncOe_n, 1'b0, "vsync driven");
        rdChk(`OFS_STATUS, 32'h1, "master active");
        busWr(`OFS_RUN_CTRL, 32'h0);
        repeat (2) @(posedge clock);
        check(hsyncOe_n, 1'b1, "hsync released");
        check(vsyncOe_n, 1'b1, "vsync released");
        summarize();
    end
endmodule
